// [common/ier_pkg.sv]
// Types shared by the input event recorder files.
// Assumes ier_regs.svh holds every number the types rely on.
package ier_pkg;

	// Edge selection of one input point
	typedef enum logic [1:0] {
		IER_EDGE_OFF = 2'h0,
		IER_EDGE_RISE = 2'h1,
		IER_EDGE_FALL = 2'h2,
		IER_EDGE_BOTH = 2'h3
	} ier_edge_t;

	typedef logic [31:0] ier_word_t;
	typedef logic [4:0] ier_point_t;
	typedef logic [11:0] ier_addr_t;

endpackage

// [common/ier_regs.svh]
// Register map, field layout, reset values and timing counts of the
// input event recorder.
// Assumes a 200 MHz clock and a 32-bit AXI4-Lite register port.
`ifndef IER_REGS_SVH
`define IER_REGS_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define IER_ADDR_W 12
`define IER_REGION_MISC 4'h0
`define IER_REGION_CFG 4'h1
`define IER_REGION_EVENT 4'h2
`define IER_OFS_PENDING 8'h00
`define IER_OFS_LEVEL 8'h04
`define IER_OFS_TIME 8'h08

// ----------------------------------------------------------------------
// Per-point configuration word
// ----------------------------------------------------------------------
`define IER_CFG_EDGE 1:0
`define IER_CFG_DEBOUNCE 15:8
`define IER_CFG_HOLDOFF 23:16
`define IER_CFG_RESET 32'h00000000
`define IER_CFG_MASK 32'h00FFFFFF
`define IER_CFG_BYTES 3

// ----------------------------------------------------------------------
// Event word
// ----------------------------------------------------------------------
`define IER_EVT_LEVEL 31
`define IER_EVT_STAMP 30:0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IER_CLK_PERIOD_NS 5
`define IER_MS_NS 1000000
`define IER_MS_CYCLES (`IER_MS_NS / `IER_CLK_PERIOD_NS)
`define IER_HOLD_TICK_MS 4'hA
`define IER_HOLD_TICKS_PER_S 15'h0064

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define IER_RESP_OKAY 2'h0
`define IER_RESP_SLVERR 2'h2

`endif

// [hdl/ier_event_mem.sv]
// Event store: one word per input point, one write and one read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ps
module ier_event_mem (
	input wire logic clock,
	input wire logic wr_en,
	input wire ier_pkg::ier_point_t wr_addr,
	input wire ier_pkg::ier_word_t wr_data,
	input wire ier_pkg::ier_point_t rd_addr,
	output ier_pkg::ier_word_t rd_data
);
	import ier_pkg::*;

	ier_word_t store [0:31];

	// Write port
	always_ff @(posedge clock) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge clock) begin
		rd_data <= store[rd_addr];
	end

endmodule

// [hdl/ier_input_event_recorder.sv]
// Input event recorder: 32 debounced inputs, per-point edge selection,
// debounce and holdoff, millisecond time stamps, AXI4-Lite registers.
// Assumes din comes straight from pins and the master keeps AXI rules.
`timescale 1ns/1ps
`include "ier_regs.svh"

module ier_input_event_recorder #(
	parameter int unsigned MS_CYCLES = `IER_MS_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [31:0] din,
	input wire ier_pkg::ier_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire ier_pkg::ier_word_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire ier_pkg::ier_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output ier_pkg::ier_word_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ier_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [31:0] sync_a;
	logic [31:0] sync_b;
	logic [17:0] prescale;
	logic ms_tick;
	logic [3:0] step_cnt;
	logic hold_tick;
	ier_word_t ms_time;
	ier_word_t stamp;
	ier_word_t cfg [0:31];
	logic [31:0] stable;
	logic [31:0] qual;
	logic [31:0] to_write;
	logic [31:0] new_level;
	logic [31:0] pending;
	logic [31:0] clr_mask;
	logic [31:0] wr_onehot;
	ier_point_t scan;
	logic mem_wr;
	ier_word_t mem_rd;
	ier_addr_t aw_addr;
	ier_word_t w_data;
	logic [3:0] w_strb;
	logic aw_got;
	logic w_got;
	logic wr_fire;
	logic wr_hit;
	ier_addr_t rd_addr;
	logic rd_stage;
	ier_word_t next_rdata;
	logic next_rerr;

	// ------------------------------------------------------------------
	// Input synchroniser and time base
	// ------------------------------------------------------------------

	// Two flops per pin before anything looks at the level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 32'h00000000;
			sync_b <= 32'h00000000;
		end else begin
			sync_a <= din;
			sync_b <= sync_a;
		end
	end

	// Millisecond prescaler
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 18'h00000;
			ms_tick <= 1'b0;
		end else if (prescale == 18'(MS_CYCLES - 1)) begin
			prescale <= 18'h00000;
			ms_tick <= 1'b1;
		end else begin
			prescale <= prescale + 18'h00001;
			ms_tick <= 1'b0;
		end
	end

	// Free-running millisecond clock for the stamps
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ms_time <= 32'h00000000;
		end else if (ms_tick) begin
			ms_time <= ms_time + 32'h00000001;
		end
	end

	// Ten-millisecond step for the holdoff counters
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			step_cnt <= 4'h0;
		end else if (ms_tick) begin
			if (step_cnt == `IER_HOLD_TICK_MS - 4'h1) begin
				step_cnt <= 4'h0;
			end else begin
				step_cnt <= step_cnt + 4'h1;
			end
		end
	end

	assign hold_tick = ms_tick && (step_cnt == 4'h0);

	// ------------------------------------------------------------------
	// Per-point debounce, edge filter and holdoff
	// ------------------------------------------------------------------
	for (genvar i = 0; i < 32; i++) begin : g_point
		ier_edge_t edge_sel;
		logic [7:0] debounce_time;
		logic [7:0] event_holdoff_time;
		logic [7:0] db_cnt;
		logic [14:0] hold_cnt;
		logic changed;
		logic settled;
		logic wanted;

		assign edge_sel = ier_edge_t'(cfg[i][`IER_CFG_EDGE]);
		assign debounce_time = cfg[i][`IER_CFG_DEBOUNCE];
		assign event_holdoff_time = cfg[i][`IER_CFG_HOLDOFF];
		assign changed = sync_b[i] != stable[i];
		assign settled = ms_tick && changed && (db_cnt >= debounce_time);

		// Direction filter on the new level
		always_comb begin
			unique case (edge_sel)
				IER_EDGE_OFF: wanted = 1'b0;
				IER_EDGE_RISE: wanted = sync_b[i];
				IER_EDGE_FALL: wanted = !sync_b[i];
				IER_EDGE_BOTH: wanted = 1'b1;
			endcase
		end

		// Blocked while holding off or while an event is unread
		assign qual[i] = settled && wanted && (hold_cnt == 15'h0000) &&
			!pending[i] && !to_write[i];

		// Debounce: count whole milliseconds of a steady new level
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				stable[i] <= 1'b0;
				db_cnt <= 8'h00;
			end else if (edge_sel == IER_EDGE_OFF) begin
				stable[i] <= sync_b[i];
				db_cnt <= 8'h00;
			end else if (ms_tick) begin
				if (!changed) begin
					db_cnt <= 8'h00;
				end else if (settled) begin
					stable[i] <= sync_b[i];
					db_cnt <= 8'h00;
				end else begin
					db_cnt <= db_cnt + 8'h01;
				end
			end
		end

		// Holdoff after each reported event, in 10 ms steps
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				hold_cnt <= 15'h0000;
			end else if (edge_sel == IER_EDGE_OFF) begin
				hold_cnt <= 15'h0000;
			end else if (qual[i]) begin
				hold_cnt <= 15'(event_holdoff_time) *
					`IER_HOLD_TICKS_PER_S;
			end else if (hold_tick && hold_cnt != 15'h0000) begin
				hold_cnt <= hold_cnt - 15'h0001;
			end
		end

		// Level latched with the event until stored
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				new_level[i] <= 1'b0;
			end else if (qual[i]) begin
				new_level[i] <= sync_b[i];
			end
		end

		assign wr_onehot[i] = mem_wr && (scan == ier_point_t'(i));
	end

	// ------------------------------------------------------------------
	// Event capture into the store
	// ------------------------------------------------------------------

	// Stamp of the millisecond in which events qualified
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stamp <= 32'h00000000;
		end else if (ms_tick) begin
			stamp <= ms_time;
		end
	end

	// Scan pointer visits every point once per 32 cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scan <= 5'h00;
		end else begin
			scan <= scan + 5'h01;
		end
	end

	assign mem_wr = to_write[scan];

	// Points waiting for their turn at the write port
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			to_write <= 32'h00000000;
		end else begin
			to_write <= (to_write & ~wr_onehot) | qual;
		end
	end

	// Pending flags; a store in the clearing cycle wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 32'h00000000;
		end else begin
			pending <= (pending & ~clr_mask) | wr_onehot;
		end
	end

	ier_event_mem u_store (
		.clock(clock),
		.wr_en(mem_wr),
		.wr_addr(scan),
		.wr_data({new_level[scan], stamp[`IER_EVT_STAMP]}),
		.rd_addr(s_axi_araddr[6:2]),
		.rd_data(mem_rd)
	);

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;
	assign wr_hit = aw_addr[11:8] == `IER_REGION_CFG &&
		aw_addr[7] == 1'b0 && aw_addr[1:0] == 2'h0;

	// Address and data taken in either order
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response; only configuration words accept writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IER_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `IER_RESP_OKAY : `IER_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration words with byte enables
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < 32; p++) begin
				cfg[p] <= `IER_CFG_RESET;
			end
		end else if (wr_fire && wr_hit) begin
			for (int b = 0; b < `IER_CFG_BYTES; b++) begin
				if (w_strb[b]) begin
					cfg[aw_addr[6:2]][b*8 +: 8] <= w_data[b*8 +: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------

	// Read data selection, one cycle after the address
	always_comb begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		unique case (rd_addr[11:8])
			`IER_REGION_MISC: begin
				if (rd_addr[7:0] == `IER_OFS_PENDING) begin
					next_rdata = pending;
				end else if (rd_addr[7:0] == `IER_OFS_LEVEL) begin
					next_rdata = stable;
				end else if (rd_addr[7:0] == `IER_OFS_TIME) begin
					next_rdata = ms_time;
				end else begin
					next_rerr = 1'b1;
				end
			end
			`IER_REGION_CFG: begin
				next_rdata = cfg[rd_addr[6:2]] & `IER_CFG_MASK;
				next_rerr = rd_addr[7] || rd_addr[1:0] != 2'h0;
			end
			`IER_REGION_EVENT: begin
				next_rdata = mem_rd;
				next_rerr = rd_addr[7] || rd_addr[1:0] != 2'h0;
			end
			default: next_rerr = 1'b1;
		endcase
	end

	// Event word read retires that point's pending flag
	always_comb begin
		clr_mask = 32'h00000000;
		if (rd_stage && rd_addr[11:8] == `IER_REGION_EVENT &&
			!next_rerr) begin
			clr_mask[rd_addr[6:2]] = 1'b1;
		end
	end

	// Address taken, one stage for the store, then the answer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IER_RESP_OKAY;
			rd_stage <= 1'b0;
			rd_addr <= 12'h000;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				rd_addr <= s_axi_araddr;
				rd_stage <= 1'b1;
				s_axi_arready <= 1'b0;
			end else if (rd_stage) begin
				rd_stage <= 1'b0;
				s_axi_rvalid <= 1'b1;
				// Refused reads answer zero data
				s_axi_rdata <= next_rerr ? 32'h00000000 : next_rdata;
				s_axi_rresp <= next_rerr ? `IER_RESP_SLVERR :
					`IER_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// [testbench/ier_host.sv]
// Host processor model: AXI4-Lite master collecting recorder events.
// Assumes the bench calls wr and rd one at a time after reset.
`timescale 1ns/1ps
module ier_host (
	input wire logic clock,
	output ier_pkg::ier_addr_t s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output ier_pkg::ier_word_t s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output ier_pkg::ier_addr_t s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire ier_pkg::ier_word_t s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	import ier_pkg::*;
	// Idle bus at time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
	end
	// One write, each channel released on its own ready
	task automatic wr(input ier_addr_t a, input ier_word_t d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!done) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				done = 1'b1;
				s_axi_bready <= 1'b0;
			end
		end
	endtask
	// One read; an event read collects and clears it
	task automatic rd(input ier_addr_t a, output ier_word_t d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!done) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				done = 1'b1;
				s_axi_rready <= 1'b0;
			end
		end
	endtask
endmodule

// [testbench/ier_properties.sv]
// Bus timing checks for the input event recorder register port.
// Assumes the top module ports only; bound below the module.
`timescale 1ns/1ps
`include "ier_regs.svh"
module ier_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire ier_pkg::ier_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire ier_pkg::ier_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire ier_pkg::ier_word_t s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ier_pkg::*;
	logic aw_cfg;
	logic ar_bad;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Address class of the request under way
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_cfg <= 1'b0;
			ar_bad <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_cfg <= s_axi_awaddr[11:7] == 5'h02 && s_axi_awaddr[1:0] == 2'h0;
			if (s_axi_arvalid && s_axi_arready)
				ar_bad <= s_axi_araddr[1:0] != 2'h0 || !((s_axi_araddr[11:4] == 8'h00
					&& s_axi_araddr[3:2] != 2'h3) || s_axi_araddr[11:7] == 5'h02
					|| s_axi_araddr[11:7] == 5'h04);
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##[0:1] s_axi_bvalid) else $error("write not answered");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> ##[1:2]
		s_axi_rvalid) else $error("read not answered");
	write_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
		(aw_cfg ? `IER_RESP_OKAY : `IER_RESP_SLVERR)) else $error("bad bresp");
	read_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp ==
		(ar_bad ? `IER_RESP_SLVERR : `IER_RESP_OKAY)) else $error("bad rresp");
	bad_read_zero_a: assert property (s_axi_rvalid && ar_bad |->
		s_axi_rdata == 32'h00000000) else $error("refused read data not zero");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready [*2]) else $error("awready back too soon");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready high during read answer");
	// Main scenarios seen
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `IER_RESP_OKAY);
	cover property (s_axi_bvalid && s_axi_bresp == `IER_RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready && ar_bad);
endmodule

bind ier_input_event_recorder ier_properties chk_u (.clock, .rst_n,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// [testbench/tb.sv]
// Self-checking bench of the input event recorder.
// Assumes a 64-cycle millisecond so the run stays short.
`timescale 1ns/1ps
`include "ier_regs.svh"
module tb;
	import ier_pkg::*;
	localparam int MS = 64;
	logic clock, rst_n;
	logic [31:0] din;
	ier_addr_t s_axi_awaddr, s_axi_araddr;
	ier_word_t s_axi_wdata, s_axi_rdata, d, t0;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int fails = 0;
	int checked = 0;
	// ----------------------------------------
	// Design, host model and clock
	// ----------------------------------------
	ier_input_event_recorder #(.MS_CYCLES(MS)) dut_u (.clock, .rst_n, .din,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	ier_host host_u (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Compare and count
	task automatic chk(input ier_word_t g, input ier_word_t e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdc(input ier_addr_t a, input ier_word_t e);
		host_u.rd(a, d, r);
		chk(d, e);
	endtask
	// Level bit of an event word
	task automatic rdl(input ier_addr_t a, input logic l);
		host_u.rd(a, d, r);
		chk({31'h0, d[31]}, {31'h0, l});
	endtask
	task automatic wait_ms(input int n);
		repeat (n * MS) @(posedge clock);
	endtask
	task automatic end_sim;
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		end_sim;
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		din = 32'h00000000;
		rst_n = 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 32; i++) rdc(12'(12'h100 + 4 * i), 32'h0);
		rdc(12'h000, 32'h0);
		host_u.wr(12'h114, 32'hFFFA0303, r);
		chk({30'h0, r}, {30'h0, `IER_RESP_OKAY});
		rdc(12'h114, 32'h00FA0303);
		host_u.wr(12'h000, 32'hFFFFFFFF, r);
		chk({30'h0, r}, {30'h0, `IER_RESP_SLVERR});
		host_u.rd(12'h300, d, r);
		chk({r, d[29:0]}, {`IER_RESP_SLVERR, 30'h0});
		// Misaligned config read is refused with zero data
		host_u.rd(12'h116, d, r);
		chk({30'h0, r}, {30'h0, `IER_RESP_SLVERR});
		chk(d, 32'h0);
		// Points 0..3 take off, rising, falling, both
		for (int i = 0; i < 4; i++)
			host_u.wr(12'(12'h100 + 4 * i), i, r);
		host_u.rd(12'h008, t0, r);
		din[3:0] <= 4'hF;
		wait_ms(3);
		rdc(12'h000, 32'h0000000A);
		din[3:0] <= 4'h0;
		wait_ms(3);
		rdc(12'h000, 32'h0000000E);
		host_u.rd(12'h20C, d, r);
		chk({31'h0, d[31]}, 32'h1);
		chk(32'(d[30:0] - t0[30:0] < 4), 32'h1);
		rdl(12'h204, 1'b1);
		rdl(12'h208, 1'b0);
		rdc(12'h000, 32'h0);
		// Zero debounce: a 2 ms pulse always reports
		din[3] <= 1'b1;
		wait_ms(2);
		din[3] <= 1'b0;
		wait_ms(3);
		rdc(12'h000, 32'h00000008);
		rdl(12'h20C, 1'b1);
		// Debounce of 3 ms on point 4
		host_u.wr(12'h110, 32'h00000303, r);
		din[4] <= 1'b1;
		wait_ms(2);
		din[4] <= 1'b0;
		wait_ms(6);
		rdc(12'h000, 32'h0);
		din[4] <= 1'b1;
		wait_ms(6);
		rdc(12'h000, 32'h00000010);
		rdl(12'h210, 1'b1);
		// Point 5 holdoff silences the change after its event
		din[5] <= 1'b1;
		wait_ms(6);
		rdc(12'h000, 32'h00000020);
		rdl(12'h214, 1'b1);
		din[5] <= 1'b0;
		wait_ms(6);
		rdc(12'h000, 32'h0);
		// Debounced levels: only point 4 still high
		rdc(12'h004, 32'h00000010);
		end_sim;
	end
endmodule
